// ### verilog/ulfc_top.v
// Line format and FIFO control logic of a serial port with transmit and receive FIFOs
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ulfc_regs.vh"
// Contract
// - Parity enable turns parity generation and checking on or off.
// - Reading parity enable position returns head-of-FIFO parity fault.
// - Stick bit forces the transmitted parity bit to one.
// - Receive threshold write-only in upper nibble; reads give receive count.
// - Receive available when receive count exceeds receive threshold.
// - Receive codes 0 to 14 give trigger levels 0 to 14.
// - Receive code 15 resets receiver and empties receive FIFO.
// - Lower nibble reads transmit count, upper nibble receive count.
// - Transmit threshold write-only in lower nibble.
// - Transmit room when transmit count below transmit threshold.
// - Transmit codes 1 to 15 give trigger levels 1 to 15.
// - Transmit code 0 resets transmitter and empties transmit FIFO.
// - Divisor zero with enable clear empties both FIFOs.
// - FIFO clear also clears overflow and underflow flags.
// - FIFO clear also zeroes the LIN counter.
// - Separate transmit and receive FIFOs of fifteen bytes each.
// - Enable bit gates transmit and receive operation.
module ulfc_top #(
  parameter DEPTH = 15
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_rxd,
  output reg o_txd,
  output reg o_irq,
  output reg o_rx_data_avail_flag,
  output reg o_tx_room_flag,
  output reg [15:0] o_lin_counter
);

  // Configuration state
  reg [7:0] serial_line_config;
  reg [3:0] rx_fill_threshold;
  reg [3:0] tx_fill_threshold;
  reg [15:0] baud_divisor;
  reg [5:0] istat;
  reg [5:0] imask;

  // FIFO storage, data plus parity fault per receive entry
  reg [7:0] tx_mem [0:DEPTH-1];
  reg [8:0] rx_mem [0:DEPTH-1];
  // Pointers and fill counts, four bits cover fifteen entries
  reg [3:0] tx_wp;
  reg [3:0] tx_rp;
  reg [3:0] tx_fill_count;
  reg [3:0] rx_wp;
  reg [3:0] rx_rp;
  reg [3:0] rx_fill_count;

  // Synchroniser for serial input
  reg rxd_m;
  reg rxd_s;

  // Line engines
  reg [15:0] tx_baud, rx_baud;
  reg [3:0] tx_bit, rx_bit;
  reg [10:0] tx_shift;
  reg tx_busy;
  reg rx_busy;
  reg [8:0] rx_shift;
  reg [3:0] rx_len;

  // Line configuration fields
  wire serial_txrx_enable = serial_line_config[`ULFC_B_EN];
  wire [1:0] char_length_sel = serial_line_config[`ULFC_B_WLS_HI:`ULFC_B_WLS_LO];
  wire parity_on = serial_line_config[`ULFC_B_PAR];
  wire parity_odd_even_sel = serial_line_config[`ULFC_B_ODD];
  wire parity_stick_one = serial_line_config[`ULFC_B_STICK];
  wire brk = serial_line_config[`ULFC_B_BRK];

  wire clr_fifo = (baud_divisor == 16'h0000) && !serial_txrx_enable;
  wire fifo_wr = i_wr && (i_addr == `ULFC_OFF_FIFO);

  wire rx_clr = clr_fifo || (fifo_wr && i_wdata[7:4] == `ULFC_RX_RESET_CODE);
  wire tx_clr = clr_fifo || (fifo_wr && i_wdata[3:0] == `ULFC_TX_RESET_CODE);

  wire [3:0] nbits = 4'h5 + {2'b00, char_length_sel};

  // Byte pushes and pops from software
  wire tx_push = i_wr && (i_addr == `ULFC_OFF_TXDATA);
  wire rx_pop = i_rd && (i_addr == `ULFC_OFF_RXDATA);
  wire tx_full = (tx_fill_count == DEPTH[3:0]);
  wire rx_full = (rx_fill_count == DEPTH[3:0]);

  wire tx_start = serial_txrx_enable && !tx_busy && !brk && (tx_fill_count != 4'h0);
  wire rx_done;
  wire rx_parity_fault;
  wire [7:0] rx_byte;

  wire [7:0] tx_head = tx_mem[tx_rp];
  wire [7:0] tx_mask = 8'hFF >> (4'h8 - nbits);
  wire tx_xor = ^(tx_head & tx_mask);
  wire tx_par = parity_stick_one ? 1'b1 : (tx_xor ^ parity_odd_even_sel ^ 1'b1);
  // Data plus parity bits, stop bits sit just above them
  wire [3:0] tx_dlen = nbits + {3'b000, parity_on};
  wire [3:0] tx_frame_len = nbits + 4'h1 + {3'b000, parity_on}
    + {3'b000, serial_line_config[`ULFC_B_STOP2]};

  // Frame image loaded at start, ones above the data keep stops high
  reg [10:0] next_tx_frame;
  always @* begin
    next_tx_frame = 11'h7FF << tx_dlen;
    next_tx_frame = next_tx_frame | {3'b000, tx_head & tx_mask};
    if (parity_on) begin
      next_tx_frame = next_tx_frame | ({10'h000, tx_par} << nbits);
    end
  end

  // Refused accesses and lost characters
  wire tx_ovf = tx_push && tx_full;
  wire rx_ovf = rx_done && rx_full;
  wire rx_unf = rx_pop && (rx_fill_count == 4'h0);

  // Register writes
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      serial_line_config <= `ULFC_RST_LINE;
      rx_fill_threshold <= `ULFC_RST_RX_FILL_THRESHOLD;
      tx_fill_threshold <= `ULFC_RST_TX_FILL_THRESHOLD;
      baud_divisor <= 16'h0000;
      imask <= 6'h00;
    end else begin
      if (i_wr && i_addr == `ULFC_OFF_LINE) serial_line_config <= i_wdata;
      if (fifo_wr) begin
        rx_fill_threshold <= i_wdata[7:4];
        tx_fill_threshold <= i_wdata[3:0];
      end
      if (i_wr && i_addr == `ULFC_OFF_BAUDL) baud_divisor[7:0] <= i_wdata;
      if (i_wr && i_addr == `ULFC_OFF_BAUDH) baud_divisor[15:8] <= i_wdata;
      if (i_wr && i_addr == `ULFC_OFF_IMASK) imask <= i_wdata[5:0];
    end
  end

  // Status events in bit order, flags raise their bits while true
  wire [5:0] ev_set = {o_tx_room_flag, o_rx_data_avail_flag, rx_done && rx_parity_fault, tx_ovf,
    rx_unf, rx_ovf};
  wire [5:0] ev_wclr = (i_wr && i_addr == `ULFC_OFF_ISTAT) ? i_wdata[5:0] : 6'h00;
  wire [5:0] ev_fclr = {3'b000, {3{clr_fifo}}};

  // Sticky status, one flop per event
  genvar gi;
  generate
    for (gi = 0; gi < `ULFC_NUM_EV; gi = gi + 1) begin : g_stat
      always @(posedge i_sys_clk) begin
        if (i_rst) begin
          istat[gi] <= 1'b0;
        end else if (ev_set[gi]) begin
          // Set wins over a clear in the same cycle
          istat[gi] <= 1'b1;
        end else if (ev_wclr[gi] || ev_fclr[gi]) begin
          istat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge i_sys_clk) begin
    if (i_rst || tx_clr) begin
      tx_wp <= 4'h0;
      tx_rp <= 4'h0;
      tx_fill_count <= 4'h0;
    end else begin
      if (tx_push && !tx_full) begin
        tx_mem[tx_wp] <= i_wdata;
        tx_wp <= (tx_wp == DEPTH[3:0] - 4'h1) ? 4'h0 : tx_wp + 4'h1;
      end
      if (tx_start) tx_rp <= (tx_rp == DEPTH[3:0] - 4'h1) ? 4'h0 : tx_rp + 4'h1;
      tx_fill_count <= tx_fill_count + {3'b000, tx_push && !tx_full}
        - {3'b000, tx_start};
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst || rx_clr) begin
      rx_wp <= 4'h0;
      rx_rp <= 4'h0;
      rx_fill_count <= 4'h0;
    end else begin
      if (rx_done && !rx_full) begin
        rx_mem[rx_wp] <= {rx_parity_fault, rx_byte};
        rx_wp <= (rx_wp == DEPTH[3:0] - 4'h1) ? 4'h0 : rx_wp + 4'h1;
      end
      if (rx_pop && rx_fill_count != 4'h0)
        rx_rp <= (rx_rp == DEPTH[3:0] - 4'h1) ? 4'h0 : rx_rp + 4'h1;
      rx_fill_count <= rx_fill_count + {3'b000, rx_done && !rx_full}
        - {3'b000, rx_pop && rx_fill_count != 4'h0};
    end
  end

  // Transmit shifter, start bit first, LSB first
  always @(posedge i_sys_clk) begin
    if (i_rst || tx_clr) begin
      tx_busy <= 1'b0;
      tx_baud <= 16'h0000;
      tx_bit <= 4'h0;
      tx_shift <= 11'h7FF;
      o_txd <= 1'b1;
    end else begin
      if (brk) begin
        o_txd <= 1'b0;
        tx_busy <= 1'b0;
      end else if (!serial_txrx_enable) begin
        o_txd <= 1'b1;
        tx_busy <= 1'b0;
      end else if (tx_start) begin
        tx_busy <= 1'b1;
        tx_baud <= baud_divisor;
        tx_bit <= tx_frame_len;
        o_txd <= 1'b0;
        tx_shift <= next_tx_frame;
      end else if (tx_busy) begin
        if (tx_baud == 16'h0000) begin
          tx_baud <= baud_divisor;
          o_txd <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[10:1]};
          tx_bit <= tx_bit - 4'h1;
          if (tx_bit == 4'h0) tx_busy <= 1'b0;
          if (tx_bit == 4'h0) o_txd <= 1'b1;
        end else begin
          tx_baud <= tx_baud - 16'h0001;
        end
      end else begin
        o_txd <= 1'b1;
      end
    end
  end

  // Two-stage input synchroniser
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
    end else begin
      rxd_m <= i_rxd;
      rxd_s <= rxd_m;
    end
  end

  reg rx_done_r;
  always @(posedge i_sys_clk) begin
    if (i_rst || rx_clr || !serial_txrx_enable) begin
      rx_busy <= 1'b0;
      rx_baud <= 16'h0000;
      rx_bit <= 4'h0;
      rx_shift <= 9'h000;
      rx_len <= 4'h0;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      if (!rx_busy) begin
        if (!rxd_s) begin
          rx_busy <= 1'b1;
          // Half a bit to land mid start bit
          rx_baud <= {1'b0, baud_divisor[15:1]};
          rx_bit <= 4'h0;
          rx_len <= nbits + {3'b000, parity_on};
        end
      end else if (rx_baud == 16'h0000) begin
        rx_baud <= baud_divisor;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rxd_s) begin
          // Line back high at mid start, a glitch
          rx_busy <= 1'b0;
        end
        if (rx_bit != 4'h0 && rx_bit <= rx_len)
          rx_shift <= {rxd_s, rx_shift[8:1]};
        if (rx_bit == rx_len + 4'h1) begin
          rx_busy <= 1'b0;
          rx_done_r <= 1'b1;
        end
      end else begin
        rx_baud <= rx_baud - 16'h0001;
      end
    end
  end
  assign rx_done = rx_done_r;

  // Align received bits to the right
  wire [8:0] rx_al = rx_shift >> (4'h9 - rx_len);
  wire [7:0] rx_dmask = 8'hFF >> (4'h8 - nbits);
  assign rx_byte = rx_al[7:0] & rx_dmask;
  wire rx_pbit = rx_al[nbits];
  wire rx_pexp = parity_stick_one ? 1'b1 : ((^rx_byte) ^ parity_odd_even_sel ^ 1'b1);
  assign rx_parity_fault = parity_on && (rx_pbit != rx_pexp);

  wire parity_fault = (rx_fill_count != 4'h0) && rx_mem[rx_rp][8];

  // Read data mux
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    case (i_addr)
      `ULFC_OFF_FIFO: next_rdata = {rx_fill_count, tx_fill_count};
      `ULFC_OFF_LINE: next_rdata = {serial_line_config[7:2], parity_fault,
        serial_line_config[0]};
      `ULFC_OFF_BAUDL: next_rdata = baud_divisor[7:0];
      `ULFC_OFF_BAUDH: next_rdata = baud_divisor[15:8];
      `ULFC_OFF_ISTAT: next_rdata = {2'b00, istat};
      `ULFC_OFF_IMASK: next_rdata = {2'b00, imask};
      `ULFC_OFF_RXDATA: next_rdata = rx_mem[rx_rp][7:0];
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data register, zero between reads
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
    end
  end

  // Level interrupt from unmasked status
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(istat & imask);
    end
  end

  // Threshold comparators
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rx_data_avail_flag <= 1'b0;
      o_tx_room_flag <= 1'b0;
    end else begin
      o_rx_data_avail_flag <= (rx_fill_count > rx_fill_threshold);
      o_tx_room_flag <= (tx_fill_count < tx_fill_threshold);
    end
  end

  // Received character counter
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_lin_counter <= 16'h0000;
    end else if (clr_fifo) begin
      o_lin_counter <= 16'h0000;
    end else if (rx_done) begin
      o_lin_counter <= o_lin_counter + 16'h0001;
    end
  end
endmodule // ulfc_top
`default_nettype wire

// ### verilog/ulfc_regs.vh
// Register offsets, field positions, reset values and codes for the line/FIFO control block
`ifndef ULFC_REGS_VH
`define ULFC_REGS_VH
`define ULFC_ADDR_W 8
`define ULFC_OFF_FIFO 8'hA5
`define ULFC_OFF_LINE 8'hC2
`define ULFC_OFF_BAUDL 8'hA8
`define ULFC_OFF_BAUDH 8'hA9
`define ULFC_OFF_ISTAT 8'hAA
`define ULFC_OFF_IMASK 8'hAB
`define ULFC_OFF_TXDATA 8'hAC
`define ULFC_OFF_RXDATA 8'hAD
`define ULFC_RST_FIFO 8'h00
`define ULFC_RST_LINE 8'h00
`define ULFC_RST_TX_FILL_THRESHOLD 4'h0
`define ULFC_RST_RX_FILL_THRESHOLD 4'h0
`define ULFC_B_EN 7
`define ULFC_B_STOP2 6
`define ULFC_B_WLS_HI 5
`define ULFC_B_WLS_LO 4
`define ULFC_B_BRK 3
`define ULFC_B_ODD 2
`define ULFC_B_PAR 1
`define ULFC_B_STICK 0
`define ULFC_RX_RESET_CODE 4'hF
`define ULFC_TX_RESET_CODE 4'h0
`define ULFC_IS_RFO 0
`define ULFC_IS_RFU 1
`define ULFC_IS_TFO 2
`define ULFC_IS_PARITY_FAULT 3
`define ULFC_IS_RDA 4
`define ULFC_IS_TRA 5
`define ULFC_NUM_EV 6
`endif

// ### sim/ulfc_props.sv
// Port checker for the line and FIFO control block
`timescale 1ns/1ps
`default_nettype none
module ulfc_props #(parameter DEPTH = 15) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_txd,
  input wire o_irq,
  input wire o_rx_data_avail_flag,
  input wire [15:0] o_lin_counter
);
  reg brk;
  reg en;
  reg [15:0] div;
  wire clr = !en && div == 16'h0000;
  wire fwr = i_wr && i_addr == 8'hA5;
  wire frd = i_rd && i_addr == 8'hA5;
  // Shadow of enable, break and divisor
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      brk <= 1'b0;
      en <= 1'b0;
      div <= 16'h0000;
    end else if (i_wr) begin
      if (i_addr == 8'hC2) {en, brk} <= {i_wdata[7], i_wdata[3]};
      if (i_addr == 8'hA8) div[7:0] <= i_wdata;
      if (i_addr == 8'hA9) div[15:8] <= i_wdata;
    end
  end
  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero");
  AST_BRK_LOW: assert property (brk && $past(brk) |-> !o_txd)
    else $error("break not low");
  AST_IDLE_HIGH: assert property (!en && !brk && $past(!en && !brk) |-> o_txd)
    else $error("line not idle");
  AST_CLR_LIN: assert property (clr && $past(clr, 3) |-> o_lin_counter == 16'h0000)
    else $error("lin counter kept");
  AST_CLR_AVAIL: assert property (clr && $past(clr, 3) |-> !o_rx_data_avail_flag)
    else $error("rx avail in clear");
  AST_CLR_LEVELS: assert property (clr && $past(clr, 3) && frd |=> o_rdata == 8'h00)
    else $error("levels kept in clear");
  AST_RX_FLUSH: assert property (fwr && i_wdata[7:4] == 4'hF ##2 frd |=> o_rdata[7:4] == 4'h0)
    else $error("rx not flushed");
  AST_TX_FLUSH: assert property (fwr && i_wdata[3:0] == 4'h0 ##2 frd |=> o_rdata[3:0] == 4'h0)
    else $error("tx not flushed");
  cover property (brk && !o_txd);
  cover property (o_rx_data_avail_flag);
  cover property (o_irq);
endmodule // ulfc_props
bind ulfc_top ulfc_props #(.DEPTH(DEPTH)) u_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_txd(o_txd), .o_irq(o_irq), .o_rx_data_avail_flag(o_rx_data_avail_flag),
  .o_lin_counter(o_lin_counter));
`default_nettype wire

// ### sim/ulfc_remote.sv
// Remote serial node: sends frames on request, captures frames
`timescale 1ns/1ps
`default_nettype none
module ulfc_remote #(parameter BIT_CLKS = 4) (
  input wire i_sys_clk,
  input wire i_send,
  input wire [8:0] i_frame,
  input wire [3:0] i_nbits,
  input wire i_txd,
  output logic o_rxd,
  output logic [8:0] o_got,
  output logic [7:0] o_got_n
);
  integer i;
  integer j;
  initial begin
    o_rxd = 1'b1;
    o_got_n = 8'h00;
  end
  // Start, bits LSB first, stop, then pulled-up idle
  always @(posedge i_sys_clk) begin
    if (i_send) begin
      for (i = 0; i < i_nbits + 2; i++) begin
        o_rxd <= (i == 0) ? 1'b0 : (i > i_nbits) ? 1'b1 : i_frame[i - 1];
        repeat (BIT_CLKS) @(posedge i_sys_clk);
      end
    end
  end
  // Sample mid-bit after the start edge
  always @(negedge i_txd) begin
    o_got = 9'h000;
    repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge i_sys_clk);
    for (j = 0; j < i_nbits; j++) begin
      o_got[j] = i_txd;
      repeat (BIT_CLKS) @(posedge i_sys_clk);
    end
    o_got_n = o_got_n + 8'h01;
  end
endmodule // ulfc_remote
`default_nettype wire

// ### sim/test_ulfc_top.sv
// Testbench for the line and FIFO control block
`timescale 1ns/1ps
`default_nettype none
module test_ulfc_top;
  logic clk, rst, wr, rd, rxd, txd, irq, ravail, troom, send;
  logic [7:0] addr, wdata, rdata, got_n;
  logic [15:0] lin;
  logic [8:0] frame, got;
  logic [3:0] nbits;
  int err_count = 0;
  int samples_checked = 0;
  ulfc_top #(.DEPTH(15)) dut (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rxd(rxd), .o_txd(txd), .o_irq(irq),
    .o_rx_data_avail_flag(ravail), .o_tx_room_flag(troom), .o_lin_counter(lin));
  ulfc_remote #(.BIT_CLKS(4)) u_remote (.i_sys_clk(clk), .i_send(send), .i_frame(frame),
    .i_nbits(nbits), .i_txd(txd), .o_rxd(rxd), .o_got(got), .o_got_n(got_n));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check("rdata", {8'h00, rdata & m}, {8'h00, e});
    @(posedge clk);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send_frame(input logic [8:0] f);
    frame <= f;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (60) @(posedge clk);
  endtask
  task automatic wait_got;
    logic [7:0] n0;
    n0 = got_n;
    for (int k = 0; k < 300 && got_n == n0; k++) @(posedge clk);
    check("frame_seen", {8'h00, got_n}, {8'h00, n0 + 8'h01});
  endtask
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    {rst, wr, rd, send} = 4'b1000;
    addr = 8'h00;
    wdata = 8'h00;
    frame = 9'h000;
    nbits = 4'h9;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'hA5, 8'hFF, 8'h00);
    wr_reg(8'hA8, 8'h03);
    wr_reg(8'hC2, 8'hB3);
    wr_reg(8'hA5, 8'h13);
    tick(2);
    check("room", troom, 1'b1);
    send_frame(9'h05A);
    rd_reg(8'hA5, 8'hF0, 8'h10);
    rd_reg(8'hC2, 8'h02, 8'h02);
    send_frame(9'h1A5);
    check("lin", lin, 16'h0002);
    for (int t = 0; t < 3; t++) begin
      wr_reg(8'hA5, {t[3:0], 4'h3});
      tick(2);
      check("avail", ravail, 1'(t < 2));
    end
    rd_reg(8'hAD, 8'hFF, 8'h5A);
    rd_reg(8'hC2, 8'h02, 8'h00);
    wr_reg(8'hA5, 8'hF3);
    rd_reg(8'hA5, 8'hF0, 8'h00);
    // Underflow raises, masks and clears the interrupt
    wr_reg(8'hAB, 8'h02);
    rd_reg(8'hAD, 8'h00, 8'h00);
    tick(2);
    check("irq", irq, 1'b1);
    wr_reg(8'hAB, 8'h00);
    tick(2);
    check("irq", irq, 1'b0);
    wr_reg(8'hAA, 8'h02);
    wr_reg(8'hAB, 8'h02);
    tick(2);
    check("irq", irq, 1'b0);
    rd_reg(8'hAD, 8'h00, 8'h00);
    // Enable off and divisor zero clear the FIFOs
    wr_reg(8'hC2, 8'h33);
    wr_reg(8'hAC, 8'h77);
    rd_reg(8'hA5, 8'h0F, 8'h01);
    wr_reg(8'hA8, 8'h00);
    tick(3);
    rd_reg(8'hA5, 8'hFF, 8'h00);
    rd_reg(8'hAA, 8'h07, 8'h00);
    check("irq", irq, 1'b0);
    check("lin", lin, 16'h0000);
    // Each length with stick parity
    wr_reg(8'hA8, 8'h03);
    for (int w = 0; w < 4; w++) begin
      nbits <= 4'(6 + w);
      wr_reg(8'hC2, {2'b10, w[1:0], 4'h3});
      wr_reg(8'hAC, 8'hA5);
      wait_got();
      check("frame", {7'h00, got}, (16'h00A5 & ((16'h1 << (5 + w)) - 16'h1))
        | (16'h1 << (5 + w)));
    end
    // Fill the idle transmit FIFO to its limit
    tick(20);
    wr_reg(8'hC2, 8'h33);
    wr_reg(8'hA5, 8'h1F);
    for (int n = 1; n <= 16; n++) begin
      wr_reg(8'hAC, n[7:0]);
      tick(1);
      check("room", troom, 1'(n < 15));
    end
    rd_reg(8'hA5, 8'h0F, 8'h0F);
    rd_reg(8'hAA, 8'h04, 8'h04);
    wr_reg(8'hA5, 8'h10);
    rd_reg(8'hA5, 8'h0F, 8'h00);
    wr_reg(8'hC2, 8'hB8);
    tick(10);
    check("txd", txd, 1'b0);
    wr_reg(8'hC2, 8'hB0);
    tick(3);
    check("txd", txd, 1'b1);
    complete_run();
  end
endmodule // test_ulfc_top
`default_nettype wire
